// file: logic/pra_port_control.sv
`timescale 1ns/10ps
`include "port_ctrl_consts.svh"
module pra_port_control
  import port_ctrl_pkg::*;
(
  input  wire logic       clk,
  input  wire logic       rst_b,
  input  wire le_req_type le_mgmt_req,
  output le_ind_type      le_mgmt_ind,
  input  wire fe_msg_type le_fe_rx,
  output fe_msg_type      le_fe_tx,
  output logic            le_l2_allow,
  output le_state_type    le_state,
  input  wire an_req_type an_mgmt_req,
  output an_ind_type      an_mgmt_ind,
  input  wire fe_msg_type an_fe_rx,
  output fe_msg_type      an_fe_tx,
  output logic            an_l2_allow,
  output logic            an_rai,
  output an_state_type    an_state
);
  an_state_type state_q, state_d;
  fe_msg_type   tx_q, tx_d;
  an_ind_type   ind_q, ind_d;
  logic         rai_q, rai_d;
  logic         l2_q, l2_d;
  logic         rx_ub, rx_blk, blocked, hi_pri;

  le_port_fsm u_le (
    .clk      (clk),
    .rst_b    (rst_b),
    .mgmt_req (le_mgmt_req),
    .fe_rx    (le_fe_rx),
    .fe_tx    (le_fe_tx),
    .mgmt_ind (le_mgmt_ind),
    .l2_allow (le_l2_allow),
    .state    (le_state)
  );

  assign rx_ub   = fe_is(an_fe_rx, `FE_UNBLOCK_REQ);
  assign rx_blk  = fe_is(an_fe_rx, `FE_BLOCK_LE);
  assign blocked = (state_q == AN_BLOCKED_1) || (state_q == AN_BLOCKED_2);
  assign hi_pri  = an_mgmt_req.block_cmd || rx_blk || an_mgmt_req.ds_fail;

  // Only one event is served per cycle; block commands, received blocks and section failures outrank the rest
  always_comb begin
    state_d = state_q;
    tx_d    = '0;
    ind_d   = '0;
    if (an_mgmt_req.block_cmd) begin
      tx_d = '{1'b1, `FE_BLOCK_AN};
      if (state_q == AN_BLOCKED_1 || state_q == AN_REMOTE_UB_1) begin
        state_d = AN_BLOCKED_1;
      end else begin
        state_d = AN_BLOCKED_2;
      end
    end else if (rx_blk) begin
      unique case (state_q)
        AN_LOCAL_UB, AN_REMOTE_UB_2, AN_OPER: begin
          state_d         = AN_BLOCKED_2;
          ind_d.block_ind = 1'b1;
        end
        AN_REMOTE_UB_1: begin
          state_d         = AN_BLOCKED_1;
          ind_d.block_ind = 1'b1;
        end
        AN_PL_OPER: ind_d.block_ind = 1'b1;
        AN_BLOCKED_1, AN_BLOCKED_2: ;
      endcase
    end else if (an_mgmt_req.ds_fail) begin
      // Already blocked: nothing new to tell the exchange
      ind_d.ds_fail_ind = 1'b1;
      if (!blocked) begin
        tx_d = '{1'b1, `FE_BLOCK_AN};
      end
      state_d = AN_BLOCKED_2;
    end else if (rx_ub) begin
      unique case (state_q)
        AN_BLOCKED_1: begin
          state_d           = AN_REMOTE_UB_1;
          ind_d.unblock_req = 1'b1;
        end
        AN_BLOCKED_2: begin
          state_d           = AN_REMOTE_UB_2;
          ind_d.unblock_req = 1'b1;
        end
        AN_LOCAL_UB, AN_PL_OPER: begin
          state_d           = AN_OPER;
          ind_d.unblock_ind = 1'b1;
        end
        AN_REMOTE_UB_1, AN_REMOTE_UB_2: ind_d.unblock_req = 1'b1;
        AN_OPER: begin
          tx_d              = '{1'b1, `FE_UNBLOCK_ACK};
          ind_d.unblock_ind = 1'b1;
        end
      endcase
    end else if (an_mgmt_req.unblock_req) begin
      unique case (state_q)
        AN_BLOCKED_1: ind_d.block_ind = 1'b1;
        AN_BLOCKED_2: begin
          tx_d    = '{1'b1, `FE_UNBLOCK_ACK};
          state_d = AN_LOCAL_UB;
        end
        AN_LOCAL_UB: tx_d = '{1'b1, `FE_UNBLOCK_ACK};
        AN_REMOTE_UB_1: begin
          // Section not yet normal, so refuse by blocking again
          tx_d            = '{1'b1, `FE_BLOCK_AN};
          ind_d.block_ind = 1'b1;
          state_d         = AN_BLOCKED_1;
        end
        AN_REMOTE_UB_2: begin
          tx_d              = '{1'b1, `FE_UNBLOCK_ACK};
          ind_d.unblock_ind = 1'b1;
          state_d           = AN_OPER;
        end
        AN_OPER: begin
          tx_d              = '{1'b1, `FE_UNBLOCK_ACK};
          ind_d.unblock_ind = 1'b1;
        end
        AN_PL_OPER: ind_d.pl_act_ind = 1'b1;
      endcase
    end else if (an_mgmt_req.pl_act_req) begin
      if (state_q == AN_LOCAL_UB) begin
        state_d          = AN_PL_OPER;
        ind_d.pl_act_ind = 1'b1;
      end
    end else if (an_mgmt_req.pl_deact_req) begin
      if (state_q == AN_PL_OPER) begin
        state_d            = AN_BLOCKED_2;
        ind_d.pl_deact_ind = 1'b1;
      end
    end else if (an_mgmt_req.block_req) begin
      if (state_q == AN_OPER) begin
        tx_d = '{1'b1, `FE_BLOCK_RQ};
      end
    end else if (an_mgmt_req.user_fail || an_mgmt_req.net_fail) begin
      if (blocked || state_q == AN_REMOTE_UB_1 || state_q == AN_REMOTE_UB_2) begin
        tx_d = '{1'b1, an_mgmt_req.user_fail ? `FE_USER_FAIL : `FE_NET_FAIL};
      end
    end else if (an_mgmt_req.ds_normal) begin
      unique case (state_q)
        AN_BLOCKED_1: begin
          state_d             = AN_BLOCKED_2;
          ind_d.ds_normal_ind = 1'b1;
        end
        AN_REMOTE_UB_1: begin
          state_d             = AN_REMOTE_UB_2;
          ind_d.ds_normal_ind = 1'b1;
        end
        AN_BLOCKED_2, AN_REMOTE_UB_2: ind_d.ds_normal_ind = 1'b1;
        AN_LOCAL_UB, AN_OPER, AN_PL_OPER: ;
      endcase
    end
    rai_d = (state_d == AN_BLOCKED_2) || (state_d == AN_LOCAL_UB)
         || (state_d == AN_REMOTE_UB_2);
    l2_d  = (state_d == AN_OPER);
  end

  always_ff @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      state_q <= AN_BLOCKED_1;
      tx_q    <= '0;
      ind_q   <= '0;
      rai_q   <= 1'b0;
      l2_q    <= 1'b0;
    end else begin
      state_q <= state_d;
      tx_q    <= tx_d;
      ind_q   <= ind_d;
      rai_q   <= rai_d;
      l2_q    <= l2_d;
    end
  end

  assign an_fe_tx    = tx_q;
  assign an_mgmt_ind = ind_q;
  assign an_rai      = rai_q;
  assign an_l2_allow = l2_q;
  assign an_state    = state_q;

  sequence s_ub_asked;
    !hi_pri && rx_ub && an_state == AN_BLOCKED_2;
  endsequence
  sequence s_ub_agreed;
    an_state == AN_REMOTE_UB_2 && !hi_pri && !rx_ub && an_mgmt_req.unblock_req;
  endsequence

  property p_an_block;
    @(posedge clk) disable iff (!rst_b)
      an_mgmt_req.block_cmd |=> fe_is(an_fe_tx, `FE_BLOCK_AN) && !an_l2_allow
        && (an_state == AN_BLOCKED_1 || an_state == AN_BLOCKED_2);
  endproperty
  a_an_block: assert property (p_an_block) else $error("access block not applied");

  property p_an_coord_ub;
    @(posedge clk) disable iff (!rst_b)
      s_ub_asked ##1 s_ub_agreed |=> an_state == AN_OPER && an_l2_allow
        && fe_is(an_fe_tx, `FE_UNBLOCK_ACK) && an_mgmt_ind.unblock_ind && !an_rai;
  endproperty
  a_an_coord_ub: assert property (p_an_coord_ub) else $error("unblock handshake broken");

  property p_an_remote_ind;
    @(posedge clk) disable iff (!rst_b)
      s_ub_asked |=> an_state == AN_REMOTE_UB_2 && an_mgmt_ind.unblock_req && !an_fe_tx.valid;
  endproperty
  a_an_remote_ind: assert property (p_an_remote_ind) else $error("remote unblock missed");

  property p_an_rai;
    @(posedge clk) disable iff (!rst_b)
      an_state == AN_LOCAL_UB |-> an_rai;
  endproperty
  a_an_rai: assert property (p_an_rai) else $error("alarm absent in local unblock");

  property p_an_ds_fail;
    @(posedge clk) disable iff (!rst_b)
      (an_mgmt_req.ds_fail && !an_mgmt_req.block_cmd && !rx_blk && an_state == AN_OPER)
        |=> an_state == AN_BLOCKED_2 && fe_is(an_fe_tx, `FE_BLOCK_AN) ##1 an_rai;
  endproperty
  a_an_ds_fail: assert property (p_an_ds_fail) else $error("failure did not block");

  property p_an_pl;
    @(posedge clk) disable iff (!rst_b)
      (an_state == AN_LOCAL_UB && !hi_pri && !rx_ub && !an_mgmt_req.unblock_req
        && an_mgmt_req.pl_act_req) |=> an_state == AN_PL_OPER && an_mgmt_ind.pl_act_ind;
  endproperty
  a_an_pl: assert property (p_an_pl) else $error("permanent line not entered");

  property p_an_pl_off;
    @(posedge clk) disable iff (!rst_b)
      (an_state == AN_PL_OPER && !hi_pri && !rx_ub && !an_mgmt_req.unblock_req
        && !an_mgmt_req.pl_act_req && an_mgmt_req.pl_deact_req)
        |=> an_state == AN_BLOCKED_2 && an_mgmt_ind.pl_deact_ind && !an_fe_tx.valid;
  endproperty
  a_an_pl_off: assert property (p_an_pl_off) else $error("permanent line not left");

  property p_an_block_req;
    @(posedge clk) disable iff (!rst_b)
      (an_state != AN_OPER && an_mgmt_req.block_req && !hi_pri && !rx_ub
        && !an_mgmt_req.unblock_req && !an_mgmt_req.pl_act_req && !an_mgmt_req.pl_deact_req)
        |=> !an_fe_tx.valid && an_state == $past(an_state);
  endproperty
  a_an_block_req: assert property (p_an_block_req) else $error("stray block request");

  property p_fail_path;
    @(posedge clk) disable iff (!rst_b)
      fe_is(an_fe_tx, `FE_USER_FAIL) && fe_is(le_fe_rx, `FE_USER_FAIL)
        && !le_mgmt_req.block_cmd && !le_mgmt_req.unblock_req |=> le_mgmt_ind.user_fail;
  endproperty
  a_fail_path: assert property (p_fail_path) else $error("user failure not reported");
endmodule : pra_port_control

// file: shared/port_ctrl_consts.svh
`ifndef PORT_CTRL_CONSTS_SVH
`define PORT_CTRL_CONSTS_SVH
// Behaviour
// - Exchange machine has a blocked state, entered at reset, no unblock started.
// - Exchange local-unblock state holds after sending unblock request, awaiting confirm.
// - Exchange remote-unblock state holds after access unblock element, own confirm pending.
// - Non-operational exchange bars layer 2 and calls; only operational allows them.
// - Access block command sends access block element, moves to blocked substate two, or one if section not yet normal.
// - Access machine blocks itself on digital section failure, always into blocked substate two.
// - Exchange block command sends exchange block element, moves to blocked.
// - Access block request sends request element only when operational; exchange passes it to management.
// - Exchange unblock request sends unblock element, moves to local-unblock.
// - Access gets unblock element: matching remote-unblock substate, tells management.
// - Access management acknowledges: send acknowledge element, become operational.
// - Exchange in local-unblock gets acknowledge: operational, unblock indication upward.
// - Unblocking is symmetric; either side may start it.
// - Remote-unblock plus peer block element: back to blocked, block indication upward.
// - User or network failure primitive sends its element only from access blocked or remote-unblock states; exchange reports the cause.
// - Permanent-line activation from local-unblock: permanent-line operational, confirmed.
// - Permanent-line deactivation: blocked substate two, indication; exchange unaffected.
// - Received block command acts at once in any state except access permanent-line operational, which only indicates it; never confirmed.
// - Access local-unblock signals remote alarm to terminal.
`define FE_CODE_W      8
`define FE_NONE        8'h00
`define FE_UNBLOCK_REQ 8'hC9
`define FE_UNBLOCK_ACK 8'hCA
`define FE_BLOCK_LE    8'hCB
`define FE_BLOCK_AN    8'hCC
`define FE_BLOCK_RQ    8'hCD
`define FE_USER_FAIL   8'hD1
`define FE_NET_FAIL    8'hD2
`endif

// file: shared/port_ctrl_pkg.sv
`include "port_ctrl_consts.svh"
package port_ctrl_pkg;
  typedef struct packed {
    logic                    valid;
    logic [`FE_CODE_W-1:0]   code;
  } fe_msg_type;
  typedef struct packed {
    logic unblock_req;
    logic block_cmd;
  } le_req_type;
  typedef struct packed {
    logic unblock_req;
    logic unblock_ind;
    logic block_ind;
    logic block_req;
    logic user_fail;
    logic net_fail;
  } le_ind_type;
  typedef struct packed {
    logic unblock_req;
    logic block_cmd;
    logic block_req;
    logic user_fail;
    logic net_fail;
    logic pl_act_req;
    logic pl_deact_req;
    logic ds_fail;
    logic ds_normal;
  } an_req_type;
  typedef struct packed {
    logic unblock_req;
    logic unblock_ind;
    logic block_ind;
    logic pl_act_ind;
    logic pl_deact_ind;
    logic ds_normal_ind;
    logic ds_fail_ind;
  } an_ind_type;
  typedef enum logic [1:0] {
    LE_BLOCKED, LE_LOCAL_UB, LE_REMOTE_UB, LE_OPER
  } le_state_type;
  typedef enum logic [2:0] {
    AN_BLOCKED_1, AN_BLOCKED_2, AN_LOCAL_UB, AN_REMOTE_UB_1,
    AN_REMOTE_UB_2, AN_OPER, AN_PL_OPER
  } an_state_type;
  function automatic logic fe_is(input fe_msg_type m, input logic [`FE_CODE_W-1:0] c);
    return m.valid && (m.code == c);
  endfunction : fe_is
endpackage : port_ctrl_pkg

// file: logic/le_port_fsm.sv
`timescale 1ns/10ps
`include "port_ctrl_consts.svh"
module le_port_fsm
  import port_ctrl_pkg::*;
(
  input  wire logic       clk,
  input  wire logic       rst_b,
  input  wire le_req_type mgmt_req,
  input  wire fe_msg_type fe_rx,
  output fe_msg_type      fe_tx,
  output le_ind_type      mgmt_ind,
  output logic            l2_allow,
  output le_state_type    state
);
  le_state_type state_q, state_d;
  fe_msg_type   tx_q, tx_d;
  le_ind_type   ind_q, ind_d;
  logic         l2_q, l2_d;

  // Block first: a block must never lose to a same-cycle unblock
  always_comb begin
    state_d = state_q;
    tx_d    = '0;
    ind_d   = '0;
    if (mgmt_req.block_cmd) begin
      tx_d    = '{1'b1, `FE_BLOCK_LE};
      state_d = LE_BLOCKED;
    end else if (fe_is(fe_rx, `FE_BLOCK_AN)) begin
      ind_d.block_ind = 1'b1;
      state_d         = LE_BLOCKED;
    end else if (mgmt_req.unblock_req) begin
      tx_d = '{1'b1, `FE_UNBLOCK_REQ};
      unique case (state_q)
        LE_BLOCKED:   state_d = LE_LOCAL_UB;
        LE_REMOTE_UB: begin
          state_d           = LE_OPER;
          ind_d.unblock_ind = 1'b1;
        end
        LE_LOCAL_UB, LE_OPER: ;
      endcase
    end else if (fe_is(fe_rx, `FE_UNBLOCK_ACK)) begin
      unique case (state_q)
        LE_BLOCKED: begin
          state_d           = LE_REMOTE_UB;
          ind_d.unblock_req = 1'b1;
        end
        LE_LOCAL_UB: begin
          state_d           = LE_OPER;
          ind_d.unblock_ind = 1'b1;
        end
        LE_REMOTE_UB, LE_OPER: ;
      endcase
    end else if (fe_is(fe_rx, `FE_BLOCK_RQ)) begin
      ind_d.block_req = 1'b1;
    end else if (fe_is(fe_rx, `FE_USER_FAIL)) begin
      ind_d.user_fail = 1'b1;
    end else if (fe_is(fe_rx, `FE_NET_FAIL)) begin
      ind_d.net_fail = 1'b1;
    end
    l2_d = (state_d == LE_OPER);
  end

  always_ff @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      state_q <= LE_BLOCKED;
      tx_q    <= '0;
      ind_q   <= '0;
      l2_q    <= 1'b0;
    end else begin
      state_q <= state_d;
      tx_q    <= tx_d;
      ind_q   <= ind_d;
      l2_q    <= l2_d;
    end
  end

  assign fe_tx    = tx_q;
  assign mgmt_ind = ind_q;
  assign l2_allow = l2_q;
  assign state    = state_q;

  property p_le_block;
    @(posedge clk) disable iff (!rst_b)
      mgmt_req.block_cmd |=> fe_is(fe_tx, `FE_BLOCK_LE) && state == LE_BLOCKED && !l2_allow;
  endproperty
  a_le_block: assert property (p_le_block) else $error("exchange block not applied");

  property p_le_peer_block;
    @(posedge clk) disable iff (!rst_b)
      (!mgmt_req.block_cmd && fe_is(fe_rx, `FE_BLOCK_AN))
        |=> state == LE_BLOCKED && mgmt_ind.block_ind && !fe_tx.valid;
  endproperty
  a_le_peer_block: assert property (p_le_peer_block) else $error("peer block ignored");

  property p_le_l2;
    @(posedge clk) disable iff (!rst_b) l2_allow == (state == LE_OPER);
  endproperty
  a_le_l2: assert property (p_le_l2) else $error("layer 2 gate wrong");
endmodule : le_port_fsm

// file: verification/fe_link_model.sv
`timescale 1ns/10ps
`include "port_ctrl_consts.svh"
module fe_link_model
  import port_ctrl_pkg::*;
(
  input  wire logic       clk,
  input  wire logic       rst_b,
  input  wire logic       link_on,
  input  wire logic       slow,
  input  wire fe_msg_type fe_in,
  input  wire fe_msg_type inj,
  output fe_msg_type      fe_out
);
  // Peer path: whole elements, in order, one or three cycles late
  fe_msg_type            pipe_d [3];
  fe_msg_type            pipe_q [3];
  fe_msg_type            tap;
  logic [`FE_CODE_W-1:0] noise_d;
  logic [`FE_CODE_W-1:0] noise_q;

  always_comb begin
    pipe_d[0] = link_on ? fe_in : '0;
    pipe_d[1] = pipe_q[0];
    pipe_d[2] = pipe_q[1];
    tap       = slow ? pipe_q[2] : pipe_q[0];
    // Idle code keeps changing, so a stale code never passes for a new one
    noise_d   = tap.valid ? ~tap.code : ~noise_q;
  end

  always_ff @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      pipe_q  <= '{default: '0};
      noise_q <= 8'hA5;
    end else begin
      pipe_q  <= pipe_d;
      noise_q <= noise_d;
    end
  end

  // Bench injection overrides link traffic; only used with the link off
  assign fe_out = inj.valid ? inj : (tap.valid ? tap : fe_msg_type'({1'b0, noise_q}));
endmodule : fe_link_model

// file: verification/tb_pra_port_control.sv
`timescale 1ns/10ps
module tb_pra_port_control import port_ctrl_pkg::*;;
  typedef struct packed {
    logic [1:0]   lr;
    logic [8:0]   ar;
    logic [7:0]   lrx;
    logic [7:0]   arx;
    logic [7:0]   ltx;
    logic [7:0]   atx;
    le_state_type ls;
    an_state_type ast;
    logic [5:0]   li;
    logic [6:0]   ai;
  } row_type;

  localparam row_type rows [33] = '{
    '{2'h0, 9'h000, 8'h00, 8'hC9, 8'h00, 8'h00, LE_BLOCKED, AN_REMOTE_UB_1, 6'h00, 7'h40},
    '{2'h0, 9'h100, 8'h00, 8'h00, 8'h00, 8'hCC, LE_BLOCKED, AN_BLOCKED_1, 6'h00, 7'h10},
    '{2'h0, 9'h001, 8'h00, 8'h00, 8'h00, 8'h00, LE_BLOCKED, AN_BLOCKED_2, 6'h00, 7'h02},
    '{2'h2, 9'h000, 8'h00, 8'h00, 8'hC9, 8'h00, LE_LOCAL_UB, AN_BLOCKED_2, 6'h00, 7'h00},
    '{2'h0, 9'h000, 8'h00, 8'hC9, 8'h00, 8'h00, LE_LOCAL_UB, AN_REMOTE_UB_2, 6'h00, 7'h40},
    '{2'h0, 9'h100, 8'h00, 8'h00, 8'h00, 8'hCA, LE_LOCAL_UB, AN_OPER, 6'h00, 7'h20},
    '{2'h0, 9'h000, 8'hCA, 8'h00, 8'h00, 8'h00, LE_OPER, AN_OPER, 6'h10, 7'h00},
    '{2'h0, 9'h040, 8'h00, 8'h00, 8'h00, 8'hCD, LE_OPER, AN_OPER, 6'h00, 7'h00},
    '{2'h0, 9'h000, 8'hCD, 8'h00, 8'h00, 8'h00, LE_OPER, AN_OPER, 6'h04, 7'h00},
    '{2'h2, 9'h000, 8'h00, 8'h00, 8'hC9, 8'h00, LE_OPER, AN_OPER, 6'h00, 7'h00},
    '{2'h0, 9'h000, 8'h00, 8'hC9, 8'h00, 8'hCA, LE_OPER, AN_OPER, 6'h00, 7'h20},
    '{2'h0, 9'h100, 8'h00, 8'h00, 8'h00, 8'hCA, LE_OPER, AN_OPER, 6'h00, 7'h20},
    '{2'h0, 9'h000, 8'hCA, 8'h00, 8'h00, 8'h00, LE_OPER, AN_OPER, 6'h00, 7'h00},
    '{2'h1, 9'h000, 8'h00, 8'h00, 8'hCB, 8'h00, LE_BLOCKED, AN_OPER, 6'h00, 7'h00},
    '{2'h0, 9'h000, 8'h00, 8'hCB, 8'h00, 8'h00, LE_BLOCKED, AN_BLOCKED_2, 6'h00, 7'h10},
    '{2'h0, 9'h040, 8'h00, 8'h00, 8'h00, 8'h00, LE_BLOCKED, AN_BLOCKED_2, 6'h00, 7'h00},
    '{2'h0, 9'h020, 8'h00, 8'h00, 8'h00, 8'hD1, LE_BLOCKED, AN_BLOCKED_2, 6'h00, 7'h00},
    '{2'h0, 9'h000, 8'hD1, 8'h00, 8'h00, 8'h00, LE_BLOCKED, AN_BLOCKED_2, 6'h02, 7'h00},
    '{2'h0, 9'h010, 8'h00, 8'h00, 8'h00, 8'hD2, LE_BLOCKED, AN_BLOCKED_2, 6'h00, 7'h00},
    '{2'h0, 9'h000, 8'hD2, 8'h00, 8'h00, 8'h00, LE_BLOCKED, AN_BLOCKED_2, 6'h01, 7'h00},
    '{2'h0, 9'h100, 8'h00, 8'h00, 8'h00, 8'hCA, LE_BLOCKED, AN_LOCAL_UB, 6'h00, 7'h00},
    '{2'h0, 9'h000, 8'hCA, 8'h00, 8'h00, 8'h00, LE_REMOTE_UB, AN_LOCAL_UB, 6'h20, 7'h00},
    '{2'h0, 9'h000, 8'hCC, 8'h00, 8'h00, 8'h00, LE_BLOCKED, AN_LOCAL_UB, 6'h08, 7'h00},
    '{2'h3, 9'h000, 8'h00, 8'h00, 8'hCB, 8'h00, LE_BLOCKED, AN_LOCAL_UB, 6'h00, 7'h00},
    '{2'h0, 9'h008, 8'h00, 8'h00, 8'h00, 8'h00, LE_BLOCKED, AN_PL_OPER, 6'h00, 7'h08},
    '{2'h0, 9'h004, 8'h00, 8'h00, 8'h00, 8'h00, LE_BLOCKED, AN_BLOCKED_2, 6'h00, 7'h04},
    '{2'h0, 9'h000, 8'h00, 8'hC9, 8'h00, 8'h00, LE_BLOCKED, AN_REMOTE_UB_2, 6'h00, 7'h40},
    '{2'h0, 9'h000, 8'h00, 8'hCB, 8'h00, 8'h00, LE_BLOCKED, AN_BLOCKED_2, 6'h00, 7'h10},
    '{2'h0, 9'h002, 8'h00, 8'h00, 8'h00, 8'h00, LE_BLOCKED, AN_BLOCKED_2, 6'h00, 7'h01},
    '{2'h0, 9'h080, 8'h00, 8'h00, 8'h00, 8'hCC, LE_BLOCKED, AN_BLOCKED_2, 6'h00, 7'h00},
    '{2'h0, 9'h100, 8'h00, 8'h00, 8'h00, 8'hCA, LE_BLOCKED, AN_LOCAL_UB, 6'h00, 7'h00},
    '{2'h0, 9'h000, 8'h00, 8'hC9, 8'h00, 8'h00, LE_BLOCKED, AN_OPER, 6'h00, 7'h20},
    '{2'h0, 9'h002, 8'h00, 8'h00, 8'h00, 8'hCC, LE_BLOCKED, AN_BLOCKED_2, 6'h00, 7'h01}
  };

  logic         clk;
  logic         rst_b;
  logic         link_on;
  logic         slow;
  le_req_type   lr;
  an_req_type   ar;
  le_ind_type   li;
  an_ind_type   ai;
  fe_msg_type   le_rx;
  fe_msg_type   an_rx;
  fe_msg_type   le_tx;
  fe_msg_type   an_tx;
  fe_msg_type   le_inj;
  fe_msg_type   an_inj;
  logic         le_l2;
  logic         an_l2;
  logic         rai;
  le_state_type le_st;
  an_state_type an_st;
  int           fail_count;
  int           n_checks;

  pra_port_control dut (.clk(clk), .rst_b(rst_b), .le_mgmt_req(lr), .le_mgmt_ind(li),
    .le_fe_rx(le_rx), .le_fe_tx(le_tx), .le_l2_allow(le_l2), .le_state(le_st),
    .an_mgmt_req(ar), .an_mgmt_ind(ai), .an_fe_rx(an_rx), .an_fe_tx(an_tx),
    .an_l2_allow(an_l2), .an_rai(rai), .an_state(an_st));
  fe_link_model to_an (.clk(clk), .rst_b(rst_b), .link_on(link_on), .slow(slow),
    .fe_in(le_tx), .inj(an_inj), .fe_out(an_rx));
  fe_link_model to_le (.clk(clk), .rst_b(rst_b), .link_on(link_on), .slow(slow),
    .fe_in(an_tx), .inj(le_inj), .fe_out(le_rx));

  initial begin
    clk = 1'b0;
    forever #25 clk = ~clk;
  end

  function automatic logic [8:0] txv(input fe_msg_type m);
    return m.valid ? {1'b1, m.code} : 9'h000;
  endfunction : txv

  task automatic chk(input string nm, input logic [8:0] got, input logic [8:0] exp);
    n_checks++;
    if (got !== exp) begin
      fail_count++;
      $display("[FAIL] %s expected %h seen %h", nm, exp, got);
    end
  endtask : chk

  task automatic put(input logic [1:0] l, input logic [8:0] a, input logic [7:0] lx,
                     input logic [7:0] ax);
    lr     = le_req_type'(l);
    ar     = an_req_type'(a);
    le_inj = fe_msg_type'({|lx, lx});
    an_inj = fe_msg_type'({|ax, ax});
  endtask : put

  task automatic check_row(input row_type r);
    chk("le_state", {7'h0, le_st}, {7'h0, r.ls});
    chk("an_state", {6'h0, an_st}, {6'h0, r.ast});
    chk("le_tx", txv(le_tx), {|r.ltx, r.ltx});
    chk("an_tx", txv(an_tx), {|r.atx, r.atx});
    chk("le_ind", {3'h0, li}, {3'h0, r.li});
    chk("an_ind", {2'h0, ai}, {2'h0, r.ai});
    chk("le_l2", {8'h0, le_l2}, {8'h0, r.ls == LE_OPER});
    chk("an_l2", {8'h0, an_l2}, {8'h0, r.ast == AN_OPER});
    chk("rai", {8'h0, rai},
        {8'h0, r.ast inside {AN_BLOCKED_2, AN_LOCAL_UB, AN_REMOTE_UB_2}});
  endtask : check_row

  task automatic do_reset();
    rst_b = 1'b0;
    repeat (10) @(negedge clk);
    chk("rst_le", {7'h0, le_st}, {7'h0, LE_BLOCKED});
    chk("rst_an", {6'h0, an_st}, {6'h0, AN_BLOCKED_1});
    chk("rst_out", {6'h0, le_l2, an_l2, rai}, 9'h000);
    rst_b = 1'b1;
  endtask : do_reset

  task automatic tally_and_finish();
    $display("checks %0d mismatches %0d", n_checks, fail_count);
    if (fail_count == 0 && n_checks > 0) begin
      $display("Run complete: PASS");
    end else begin
      $display("Run complete: FAIL");
    end
    $finish;
  endtask : tally_and_finish

  initial begin
    lr         = '0;
    ar         = '0;
    le_inj     = '0;
    an_inj     = '0;
    link_on    = 1'b0;
    slow       = 1'b0;
    fail_count = 0;
    n_checks   = 0;
    do_reset();
    foreach (rows[i]) begin
      put(rows[i].lr, rows[i].ar, rows[i].lrx, rows[i].arx);
      @(negedge clk);
      check_row(rows[i]);
    end
    put(2'h0, 9'h000, 8'h00, 8'h00);
    // Mid-run reset, then both machines talk through the link model
    do_reset();
    link_on = 1'b1;
    put(2'h0, 9'h001, 8'h00, 8'h00);
    @(negedge clk);
    put(2'h0, 9'h000, 8'h00, 8'h00);
    for (int s = 0; s < 2; s++) begin
      slow = s[0];
      // Drain the pipe, else the new tap replays an old block element
      repeat (4) @(negedge clk);
      put(2'h2, 9'h000, 8'h00, 8'h00);
      @(negedge clk);
      put(2'h0, 9'h000, 8'h00, 8'h00);
      for (int k = 0; k < 12 && ai.unblock_req !== 1'b1; k++) @(negedge clk);
      chk("an_ub_req", {8'h0, ai.unblock_req}, 9'h001);
      put(2'h0, 9'h100, 8'h00, 8'h00);
      @(negedge clk);
      put(2'h0, 9'h000, 8'h00, 8'h00);
      for (int k = 0; k < 12 && le_st !== LE_OPER; k++) @(negedge clk);
      chk("walk_oper", {5'h0, le_l2, an_l2, rai, an_st == AN_OPER}, 9'h00D);
      // Access block command from operational; the exchange follows the block element
      put(2'h0, 9'h080, 8'h00, 8'h00);
      @(negedge clk);
      put(2'h0, 9'h000, 8'h00, 8'h00);
      for (int k = 0; k < 12 && le_st !== LE_BLOCKED; k++) @(negedge clk);
      chk("walk_blk", {5'h0, le_l2, an_l2, rai, an_st == AN_BLOCKED_2}, 9'h003);
    end
    tally_and_finish();
  end

  // Whole run is at most about 140 cycles; the 3000-cycle limit leaves wide margin
  initial begin
    #(50 * 3000);
    fail_count++;
    tally_and_finish();
  end
endmodule : tb_pra_port_control
